// ===== rtl/scss_ctl_if.sv
`timescale 1ns/100ps
`default_nettype none
// control word and failure events between the register file and the failure monitor
interface scss_ctl_if;
   logic [7:0] ctrl;
   logic sys_fail;
   logic wd_fail;
   modport regs (output ctrl, input sys_fail, wd_fail);
   modport mux (input ctrl, output sys_fail, wd_fail);
endinterface
`default_nettype wire

// ===== rtl/scss_fail_mon.sv
`timescale 1ns/100ps
`default_nettype none
module scss_fail_mon
   import scss_pkg::*;
#(
   parameter int WD_TIMEOUT = 8004,
   parameter int SYS_TIMEOUT = 8004
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wd_tick,
   input wire logic sys_tick,
   scss_ctl_if.mux ctl
);
   typedef struct packed {
      logic [13:0] wd_cnt;
      logic [13:0] sys_cnt;
      logic wd_dead;
      logic sys_fail;
      logic wd_fail;
   } scss_mon_s;
   scss_mon_s m_q, m_d;
   logic wd_on, sys_on;

   // detection needs a live watchdog clock and must not watch itself
   assign wd_on = ctl.ctrl[BIT_WDFAIL_EN] && ctl.ctrl[BIT_WDOG_EN] && ctl.ctrl[2:0] != SRC_WDOG;
   assign sys_on = ctl.ctrl[BIT_SYSFAIL_EN] && ctl.ctrl[BIT_WDOG_EN] && !m_q.wd_dead
                   && ctl.ctrl[2:0] != SRC_WDOG;

   // count idle cycles since the last tick of the watchdog oscillator and of the selected source
   always_comb begin
      m_d = m_q;
      m_d.wd_fail = 1'b0;
      m_d.sys_fail = 1'b0;
      if (!wd_on || wd_tick) m_d.wd_cnt = 14'h0;
      else if (m_q.wd_cnt == 14'(WD_TIMEOUT - 1)) begin
         m_d.wd_cnt = 14'h0;
         m_d.wd_fail = 1'b1;
         m_d.wd_dead = 1'b1;
      end else m_d.wd_cnt = m_q.wd_cnt + 14'h1;
      if (!sys_on || sys_tick) m_d.sys_cnt = 14'h0;
      else if (m_q.sys_cnt == 14'(SYS_TIMEOUT - 1)) begin
         m_d.sys_cnt = 14'h0;
         m_d.sys_fail = 1'b1;
      end else m_d.sys_cnt = m_q.sys_cnt + 14'h1;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) m_q <= '0;
      else m_q <= m_d;
   end

   assign ctl.sys_fail = m_q.sys_fail;
   assign ctl.wd_fail = m_q.wd_fail;
endmodule
`default_nettype wire

// ===== rtl/scss_pkg.sv
package scss_pkg;
   // register map, byte addresses on the wishbone slave
   localparam logic [3:0] OSC_CTRL_ADDR = 4'h0;
   localparam logic [3:0] TRIM_ADDR = 4'h4;
   localparam logic [3:0] IRQ_STATUS_ADDR = 4'h8;
   localparam logic [3:0] IRQ_MASK_ADDR = 4'hC;
   // oscillator control fields
   localparam int BIT_INT_EN = 7;
   localparam int BIT_XTAL_EN = 6;
   localparam int BIT_WDOG_EN = 5;
   localparam int BIT_SYSFAIL_EN = 4;
   localparam int BIT_WDFAIL_EN = 3;
   localparam logic [7:0] OSC_CTRL_RESET = 8'hA0;
   localparam logic [7:0] UNLOCK_FIRST = 8'hE7;
   localparam logic [7:0] UNLOCK_SECOND = 8'h18;
   // source select codes
   localparam logic [2:0] SRC_INT_FAST = 3'h0;
   localparam logic [2:0] SRC_INT_SLOW = 3'h1;
   localparam logic [2:0] SRC_CRYSTAL = 3'h2;
   localparam logic [2:0] SRC_WDOG = 3'h3;
   localparam logic [2:0] SRC_EXT_PIN = 3'h4;
   // interrupt status bits
   localparam int IRQ_SYSFAIL = 0;
   localparam int IRQ_WDFAIL = 1;
   localparam int IRQ_BAD_SEQ = 2;
   // crystal gain modes from option bits
   typedef enum logic [1:0] {XTAL_LOW, XTAL_MED, XTAL_HIGH, XTAL_RC} scss_xmode_e;
   typedef enum logic [1:0] {LK_LOCKED, LK_FIRST_OK, LK_OPEN} scss_lock_e;
endpackage

// ===== rtl/scss_top.sv
`timescale 1ns/100ps
`default_nettype none
module scss_top
   import scss_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic IRQ,
   input wire logic CRYSTAL_RESET_DISABLE_OPT,
   input wire logic [1:0] CRYSTAL_MODE_OPT,
   input wire logic [7:0] TRIM_OPT,
   input wire logic INT_FAST_TICK,
   input wire logic INT_SLOW_TICK,
   input wire logic CRYSTAL_INPUT_PIN,
   input wire logic WDOG_OSC_TICK,
   input wire logic EXTERNAL_CLOCK_PIN,
   output logic [2:0] SYSCLK_SOURCE_SELECT,
   output logic SYSCLK_TICK,
   output logic INT_OSC_EN,
   output logic INT_OSC_SLOW,
   output logic [7:0] INT_OSC_TRIM,
   output logic CRYSTAL_EN,
   output logic [1:0] CRYSTAL_GAIN_MODE,
   output logic WDOG_OSC_EN
);
   scss_ctl_if ctl_bus();
   logic [31:0] dat_r;
   logic ack, irq;
   logic [7:0] trim;
   logic [2:0] msel;
   logic sel_tick;

   // register file and unlock guard
   scss_wb_regs u_regs (
      .clk(CLK),
      .reset_n(RESET_N),
      .xtal_reset_disable(CRYSTAL_RESET_DISABLE_OPT),
      .trim_default(TRIM_OPT),
      .cyc(WB_CYC_I),
      .stb(WB_STB_I),
      .we(WB_WE_I),
      .adr(WB_ADR_I),
      .sel(WB_SEL_I),
      .dat_w(WB_DAT_I),
      .dat_r(dat_r),
      .ack(ack),
      .irq(irq),
      .trim(trim),
      .mux_sel(msel),
      .ctl(ctl_bus.regs)
   );

   // selected clock fed back so a stalled source is noticed
   scss_fail_mon u_mon (
      .clk(CLK),
      .reset_n(RESET_N),
      .wd_tick(WDOG_OSC_TICK),
      .sys_tick(sel_tick),
      .ctl(ctl_bus.mux)
   );

   // source mux; no divider anywhere, the crystal level goes straight through
   always_comb begin
      unique case (msel)
         SRC_INT_FAST: sel_tick = INT_FAST_TICK;
         SRC_INT_SLOW: sel_tick = INT_SLOW_TICK;
         SRC_CRYSTAL: sel_tick = CRYSTAL_INPUT_PIN;
         SRC_WDOG: sel_tick = WDOG_OSC_TICK;
         SRC_EXT_PIN: sel_tick = EXTERNAL_CLOCK_PIN;
         default: sel_tick = 1'b0;
      endcase
   end

   typedef struct packed {
      logic [31:0] dat;
      logic ack;
      logic irq;
      logic [2:0] src;
      logic tick;
      logic int_en;
      logic int_slow;
      logic [7:0] trim;
      logic xtal_en;
      logic [1:0] gain;
      logic wd_en;
   } scss_out_s;
   scss_out_s o_q, o_d;

   // output staging so every port leaves a flop
   always_comb begin
      o_d = o_q;
      o_d.dat = dat_r;
      o_d.ack = ack;
      o_d.irq = irq;
      o_d.src = msel;
      o_d.tick = sel_tick;
      o_d.int_en = ctl_bus.ctrl[BIT_INT_EN];
      o_d.int_slow = (msel == SRC_INT_SLOW);
      o_d.trim = trim;
      o_d.xtal_en = ctl_bus.ctrl[BIT_XTAL_EN];
      o_d.gain = CRYSTAL_MODE_OPT;
      o_d.wd_en = ctl_bus.ctrl[BIT_WDOG_EN];
   end

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         o_q <= '{dat: 32'h0, ack: 1'b0, irq: 1'b0, src: SRC_INT_FAST, tick: 1'b0, int_en: 1'b1,
                  int_slow: 1'b0, trim: 8'h00, xtal_en: 1'b0, gain: 2'h0, wd_en: 1'b1};
      end else begin
         o_q <= o_d;
      end
   end

   // ack delayed one flop; the bus slave is still single-answer per request
   assign WB_DAT_O = o_q.dat;
   assign WB_ACK_O = o_q.ack;
   assign IRQ = o_q.irq;
   assign SYSCLK_SOURCE_SELECT = o_q.src;
   assign SYSCLK_TICK = o_q.tick;
   assign INT_OSC_EN = o_q.int_en;
   assign INT_OSC_SLOW = o_q.int_slow;
   assign INT_OSC_TRIM = o_q.trim;
   assign CRYSTAL_EN = o_q.xtal_en;
   assign CRYSTAL_GAIN_MODE = o_q.gain;
   assign WDOG_OSC_EN = o_q.wd_en;
endmodule
`default_nettype wire

// ===== rtl/scss_wb_regs.sv
`timescale 1ns/100ps
`default_nettype none
module scss_wb_regs
   import scss_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic xtal_reset_disable,
   input wire logic [7:0] trim_default,
   input wire logic cyc,
   input wire logic stb,
   input wire logic we,
   input wire logic [3:0] adr,
   input wire logic [3:0] sel,
   input wire logic [31:0] dat_w,
   output logic [31:0] dat_r,
   output logic ack,
   output logic irq,
   output logic [7:0] trim,
   output logic [2:0] mux_sel,
   scss_ctl_if.regs ctl
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] trim;
      logic [2:0] status;
      logic [2:0] mask;
      scss_lock_e lock;
      logic [31:0] rdata;
      logic ack;
      logic ack_tail;
      logic irq;
      logic init;
   } scss_regs_s;
   scss_regs_s r_q, r_d;
   logic take, wr, rd;
   logic [7:0] wbyte;
   logic [2:0] ev;

   // ack leaves through one more flop in the top, so the master still holds its request
   // in the cycle after our ack; the tail bit stops that cycle from being taken twice
   assign take = cyc && stb && !r_q.ack && !r_q.ack_tail;
   assign wr = take && we && sel[0];
   assign rd = take;
   assign wbyte = dat_w[7:0];
   assign ctl.ctrl = r_q.ctrl;
   assign mux_sel = r_q.ctrl[2:0];

   // next state: unlock sequence, write-one-clear, strap capture after reset
   always_comb begin
      r_d = r_q;
      ev = 3'h0;
      ev[IRQ_SYSFAIL] = ctl.sys_fail;
      ev[IRQ_WDFAIL] = ctl.wd_fail;
      r_d.ack = take;
      r_d.ack_tail = r_q.ack;
      if (r_q.init) begin
         // option bits caught one cycle after release, never inside reset
         r_d.init = 1'b0;
         r_d.ctrl[BIT_XTAL_EN] = !xtal_reset_disable;
         r_d.trim = trim_default;
      end
      if (wr && adr == OSC_CTRL_ADDR) begin
         unique case (r_q.lock)
            LK_LOCKED: begin
               if (wbyte == UNLOCK_FIRST) r_d.lock = LK_FIRST_OK;
               else ev[IRQ_BAD_SEQ] = 1'b1;
            end
            LK_FIRST_OK: begin
               // a repeated first key keeps the sequence alive
               if (wbyte == UNLOCK_SECOND) r_d.lock = LK_OPEN;
               else if (wbyte != UNLOCK_FIRST) begin
                  r_d.lock = LK_LOCKED;
                  ev[IRQ_BAD_SEQ] = 1'b1;
               end
            end
            LK_OPEN: begin
               r_d.lock = LK_LOCKED;
               r_d.ctrl[7:3] = wbyte[7:3];
               // reserved codes keep the running source
               if (wbyte[2:0] <= SRC_EXT_PIN) r_d.ctrl[2:0] = wbyte[2:0];
            end
            default: r_d.lock = LK_LOCKED;
         endcase
      end
      if (wr && adr == TRIM_ADDR) r_d.trim = wbyte;
      if (wr && adr == IRQ_MASK_ADDR) r_d.mask = wbyte[2:0];
      // set beats clear so a same-cycle event survives
      if (wr && adr == IRQ_STATUS_ADDR) r_d.status = r_q.status & ~wbyte[2:0];
      r_d.status = r_d.status | ev;
      // recovery forces the watchdog oscillator in the visible select field
      if (ctl.sys_fail) r_d.ctrl[2:0] = SRC_WDOG;
      r_d.irq = |(r_d.status & r_d.mask);
      r_d.rdata = 32'h0;
      if (rd) begin
         unique case (adr)
            OSC_CTRL_ADDR: r_d.rdata = {24'h0, r_q.ctrl};
            TRIM_ADDR: r_d.rdata = {24'h0, r_q.trim};
            IRQ_STATUS_ADDR: r_d.rdata = {29'h0, r_q.status};
            IRQ_MASK_ADDR: r_d.rdata = {29'h0, r_q.mask};
            default: r_d.rdata = 32'h0;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_q <= '{ctrl: OSC_CTRL_RESET, trim: 8'h00, status: 3'h0, mask: 3'h0,
                  lock: LK_LOCKED, rdata: 32'h0, ack: 1'b0, ack_tail: 1'b0, irq: 1'b0, init: 1'b1};
      end else begin
         r_q <= r_d;
      end
   end

   assign dat_r = r_q.rdata;
   assign ack = r_q.ack;
   assign irq = r_q.irq;
   assign trim = r_q.trim;
endmodule
`default_nettype wire

// ===== test/scss_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module scss_assertions
   import scss_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_ADR_I,
   input wire logic WB_ACK_O,
   input wire logic IRQ,
   input wire logic CRYSTAL_RESET_DISABLE_OPT,
   input wire logic [1:0] CRYSTAL_MODE_OPT,
   input wire logic [7:0] TRIM_OPT,
   input wire logic CRYSTAL_INPUT_PIN,
   input wire logic EXTERNAL_CLOCK_PIN,
   input wire logic [2:0] SYSCLK_SOURCE_SELECT,
   input wire logic SYSCLK_TICK,
   input wire logic INT_OSC_SLOW,
   input wire logic [7:0] INT_OSC_TRIM,
   input wire logic CRYSTAL_EN,
   input wire logic [1:0] CRYSTAL_GAIN_MODE
);
   logic [1:0] up_q;
   logic wr_ctl;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // edges since reset release; straps reach the outputs on the second
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end
   assign wr_ctl = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == OSC_CTRL_ADDR;
   // tick may sit behind a short synchroniser, so allow one to three stages
   property p_tick(logic [2:0] c, logic p);
      SYSCLK_SOURCE_SELECT == c && $past(SYSCLK_SOURCE_SELECT, 4) == c |->
         SYSCLK_TICK == $past(p, 1) || SYSCLK_TICK == $past(p, 2) || SYSCLK_TICK == $past(p, 3);
   endproperty
   a_sel_legal: assert property (SYSCLK_SOURCE_SELECT <= SRC_EXT_PIN)
      else $error("select holds a reserved code");
   a_sel_by_write: assert property ($changed(SYSCLK_SOURCE_SELECT) && SYSCLK_SOURCE_SELECT != SRC_WDOG
      |-> $past(wr_ctl, 1) || $past(wr_ctl, 2) || $past(wr_ctl, 3))
      else $error("select moved without a control write");
   a_ack_timing: assert property ($rose(WB_CYC_I && WB_STB_I) |-> ##2 WB_ACK_O ##1 !WB_ACK_O)
      else $error("ack not two cycles after request");
   a_trim_default: assert property (up_q == 2'h2 |-> INT_OSC_TRIM == TRIM_OPT)
      else $error("trim not loaded from option bits");
   a_xtal_strap: assert property (up_q == 2'h2 |-> CRYSTAL_EN == !CRYSTAL_RESET_DISABLE_OPT)
      else $error("crystal enable ignores strap");
   a_gain_mode: assert property (up_q == 2'h3 && $stable(CRYSTAL_MODE_OPT) |-> CRYSTAL_GAIN_MODE == CRYSTAL_MODE_OPT)
      else $error("gain mode differs from option bits");
   a_slow_mode: assert property ($stable(SYSCLK_SOURCE_SELECT) && SYSCLK_SOURCE_SELECT <= SRC_INT_SLOW
      |-> INT_OSC_SLOW == SYSCLK_SOURCE_SELECT[0])
      else $error("internal oscillator rate wrong");
   a_xtal_tick: assert property (p_tick(SRC_CRYSTAL, CRYSTAL_INPUT_PIN))
      else $error("crystal input not passed undivided");
   a_ext_tick: assert property (p_tick(SRC_EXT_PIN, EXTERNAL_CLOCK_PIN))
      else $error("external pin not passed through");
   c_xtal: cover property (SYSCLK_SOURCE_SELECT == SRC_CRYSTAL);
   c_irq: cover property ($rose(IRQ));
   c_recover: cover property ($past(SYSCLK_SOURCE_SELECT) == SRC_CRYSTAL && SYSCLK_SOURCE_SELECT == SRC_WDOG);
endmodule
`default_nettype wire

// ===== test/system_clock_source_select_test.sv
`timescale 1ns/100ps
`default_nettype none
module system_clock_source_select_test
   import scss_pkg::*;
;
   logic CLK, RESET_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, IRQ, CRYSTAL_RESET_DISABLE_OPT, SYSCLK_TICK;
   logic INT_FAST_TICK, INT_SLOW_TICK, CRYSTAL_INPUT_PIN, WDOG_OSC_TICK, EXTERNAL_CLOCK_PIN;
   logic INT_OSC_EN, INT_OSC_SLOW, CRYSTAL_EN, WDOG_OSC_EN, x_run, w_run;
   logic [3:0] WB_ADR_I, WB_SEL_I;
   logic [31:0] WB_DAT_I, WB_DAT_O, lfsr;
   logic [1:0] CRYSTAL_MODE_OPT, CRYSTAL_GAIN_MODE;
   logic [7:0] TRIM_OPT, INT_OSC_TRIM, rd;
   logic [2:0] SYSCLK_SOURCE_SELECT;
   int error_cnt, n_checks, cyc_n, m_ctrl, m_stat, lk, m_trim;
   scss_top dut (.*);
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // oscillator levels from the lfsr; a cleared run flag models a dead source
   always @(posedge CLK) begin
      lfsr <= nxt(lfsr);
      {INT_FAST_TICK, INT_SLOW_TICK, EXTERNAL_CLOCK_PIN} <= lfsr[2:0];
      CRYSTAL_INPUT_PIN <= x_run & lfsr[3];
      WDOG_OSC_TICK <= w_run & lfsr[4];
      cyc_n <= cyc_n + 1;
      if (cyc_n == 40000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // one classic cycle; request held until ack is sampled
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} <= {2'b11, w, a, 4'hF, 24'h0, d};
      do begin
         @(posedge CLK);
         n++;
      end while (WB_ACK_O !== 1'b1 && n < 16);
      rd = WB_DAT_O[7:0];
      {WB_CYC_I, WB_STB_I} <= 2'b00;
      if (n == 16) chk("ack", 1, 0);
   endtask
   // write plus model update: keys, then one value, reserved codes keep select
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
      if (a == TRIM_ADDR) m_trim = d;
      if (a == IRQ_STATUS_ADDR) m_stat &= ~d;
      if (a != OSC_CTRL_ADDR) return;
      if (lk == 2) m_ctrl = (d[2:0] > SRC_EXT_PIN) ? {d[7:3], m_ctrl[2:0]} : d;
      if (lk == 2) lk = 0;
      else if (d == UNLOCK_FIRST) lk = 1;
      else if (lk == 1 && d == UNLOCK_SECOND) lk = 2;
      else {lk, m_stat} = {32'h0, m_stat | 4};
   endtask
   task automatic rchk(input string n, input logic [3:0] a, input int e);
      bus(1'b0, a, 8'h00);
      chk(n, e, rd);
   endtask
   task automatic setc(input logic [7:0] d);
      wr(OSC_CTRL_ADDR, UNLOCK_FIRST);
      rchk("trim", TRIM_ADDR, m_trim);
      wr(OSC_CTRL_ADDR, UNLOCK_SECOND);
      wr(OSC_CTRL_ADDR, d);
   endtask
   initial begin
      {RESET_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, CRYSTAL_RESET_DISABLE_OPT} = '0;
      {INT_FAST_TICK, INT_SLOW_TICK, CRYSTAL_INPUT_PIN, WDOG_OSC_TICK, EXTERNAL_CLOCK_PIN} = '0;
      {WB_SEL_I, CRYSTAL_MODE_OPT, TRIM_OPT, x_run, w_run} = {4'hF, 2'h2, 8'h6C, 2'b11};
      {lfsr, cyc_n, m_ctrl, m_stat, lk} = {32'hE9A3, 32'h0, 32'hE0, 64'h0};
      m_trim = TRIM_OPT;
      repeat (10) @(posedge CLK);
      RESET_N <= 1'b1;
      repeat (2) @(posedge CLK);
      rchk("ctrl", OSC_CTRL_ADDR, m_ctrl);
      rchk("trim", TRIM_ADDR, m_trim);
      rchk("unmapped", 4'h2, 0);
      chk("gain", CRYSTAL_MODE_OPT, CRYSTAL_GAIN_MODE);
      chk("xen", 1, CRYSTAL_EN);
      $display("test reset done");
      wr(OSC_CTRL_ADDR, 8'h02);
      rchk("ctrl", OSC_CTRL_ADDR, m_ctrl);
      rchk("stat", IRQ_STATUS_ADDR, m_stat);
      chk("irq", 0, IRQ);
      wr(IRQ_MASK_ADDR, 8'h04);
      repeat (2) @(posedge CLK);
      chk("irq", 1, IRQ);
      wr(IRQ_STATUS_ADDR, 8'h07);
      repeat (2) @(posedge CLK);
      chk("irq", 0, IRQ);
      // keys out of order must not open the register
      wr(OSC_CTRL_ADDR, UNLOCK_SECOND);
      wr(OSC_CTRL_ADDR, UNLOCK_FIRST);
      wr(OSC_CTRL_ADDR, 8'h02);
      rchk("ctrl", OSC_CTRL_ADDR, m_ctrl);
      wr(IRQ_STATUS_ADDR, 8'h07);
      $display("test lock done");
      for (int c = 0; c < 8; c++) begin
         // internal and watchdog oscillator enables follow the loop count, crystal stays on
         setc({c[0], 1'b1, c[1], 2'b00, c[2:0]});
         repeat (6) @(posedge CLK);
         chk("sel", m_ctrl[2:0], SYSCLK_SOURCE_SELECT);
         chk("slow", m_ctrl[2:0] == 1, INT_OSC_SLOW);
         chk("osc_en", {m_ctrl[7], m_ctrl[5]}, {INT_OSC_EN, WDOG_OSC_EN});
         rchk("ctrl", OSC_CTRL_ADDR, m_ctrl);
      end
      wr(TRIM_ADDR, 8'h5A);
      repeat (2) @(posedge CLK);
      chk("trim", m_trim, INT_OSC_TRIM);
      $display("test select done");
      // dead crystal while selected: recovery onto the watchdog oscillator
      // crystal has run since reset, far past its settling time, before it is selected
      setc(8'hF2);
      x_run <= 1'b0;
      repeat (8100) @(posedge CLK);
      chk("sel", SRC_WDOG, SYSCLK_SOURCE_SELECT);
      rchk("stat", IRQ_STATUS_ADDR, 1);
      wr(IRQ_STATUS_ADDR, 8'h07);
      {x_run, w_run} <= 2'b10;
      repeat (8100) @(posedge CLK);
      rchk("stat", IRQ_STATUS_ADDR, 0);
      setc(8'hE8);
      repeat (8100) @(posedge CLK);
      rchk("stat", IRQ_STATUS_ADDR, 2);
      $display("test failure done");
      // second reset in mid-run with the crystal strapped off
      CRYSTAL_RESET_DISABLE_OPT <= 1'b1;
      RESET_N <= 1'b0;
      repeat (10) @(posedge CLK);
      RESET_N <= 1'b1;
      {m_ctrl, m_stat, lk} = {32'hA0, 64'h0};
      m_trim = TRIM_OPT;
      repeat (2) @(posedge CLK);
      rchk("ctrl", OSC_CTRL_ADDR, m_ctrl);
      rchk("trim", TRIM_ADDR, m_trim);
      chk("xen", 0, CRYSTAL_EN);
      $display("test strap done");
      final_report();
   end
endmodule
bind scss_top scss_assertions u_chk (.*);
`default_nettype wire
